// ===== verilog/urs_rx_status_reporter.sv
`timescale 1ns/1ps
// decides when the transceiver sends receive-status bytes and owns the bus
`include "urs_regs.svh"
module urs_rx_status_reporter
	import urs_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// mode
	input  wire logic       syncMode,
	input  wire logic       exitLowPower,
	input  wire logic       txActive,
	// line and comparator state
	input  wire logic [1:0] lineState,
	input  wire logic [1:0] vbusState,
	input  wire logic       idState,
	// receive path
	input  wire logic       rxActive,
	input  wire logic       rxError,
	input  wire logic       rxDataValid,
	input  wire logic [7:0] rxData,
	// link pins
	input  wire logic       stp,
	input  wire logic [7:0] dataIn,
	output logic            dir,
	output logic            nxt,
	output logic [7:0]      dataOut,
	output logic            dataOe,
	// data the link drove, taken outside turnaround
	output logic [7:0]      linkData,
	output logic            linkDataValid
);
	urs_bus_e   bus_q;
	logic       pend_q;
	logic       startup_q;
	logic [1:0] lineLast_q;
	logic [1:0] vbusLast_q;
	logic       idLast_q;
	logic       txHeld_q;
	logic       stpSeen_q;
	urs_byte_t  statusByte;
	logic       trigger;
	logic       wantBus;
	logic       lineTrig;
	logic       compTrig;
	logic       wakeTrig;
	logic       txDoneTrig;
	logic       keepBus;

	urs_status_byte u_byte (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.lineState  (lineState),
		.vbusState  (vbusState),
		.rxActive   (rxActive),
		.rxError    (rxError),
		.idState    (idState),
		.statusByte (statusByte)
	);

	// line change counts only while direction low; comparators always
	always_comb begin
		lineTrig   = (lineState != lineLast_q) && !dir;
		compTrig   = (vbusState != vbusLast_q)
			|| (idState != idLast_q);
		wakeTrig   = exitLowPower && stp;
		txDoneTrig = txHeld_q && stpSeen_q;
		trigger    = lineTrig || compTrig || wakeTrig || txDoneTrig;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineLast_q <= 2'h0;
			vbusLast_q <= 2'h0;
			idLast_q   <= 1'b0;
		end else begin
			if (!dir)
				lineLast_q <= lineState;
			vbusLast_q <= vbusState;
			idLast_q   <= idState;
		end
	end

	// transmit hold: reports wait until stop ends the transmit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			txHeld_q  <= 1'b0;
			stpSeen_q <= 1'b0;
		end else begin
			if (txActive)
				txHeld_q <= 1'b1;
			else if (stpSeen_q)
				txHeld_q <= 1'b0;
			stpSeen_q <= txActive && stp;
		end
	end

	// pending report; a new trigger wins over the clear, merged into one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (trigger) begin
			pend_q <= 1'b1;
		end else if (bus_q == URS_BUS_PHY && !rxActive) begin
			pend_q <= 1'b0;
		end
	end

	// start-up: bus released with stop low, then one report
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			startup_q <= 1'b1;
		end else if (startup_q && !stp && syncMode) begin
			startup_q <= 1'b0;
		end
	end

	// a fresh trigger takes the bus at once, a held one waits in pend_q
	assign wantBus = syncMode && !(txActive || (txHeld_q && !stpSeen_q))
		&& (pend_q || trigger || rxActive
		|| (startup_q && !stp));

	assign keepBus = (bus_q == URS_BUS_PHY) && (rxActive || trigger);

	// bus ownership with a turnaround cycle on each change
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= URS_BUS_LINK;
		end else begin
			case (bus_q)
				URS_BUS_LINK: begin
					if (wantBus)
						bus_q <= URS_BUS_TURN_IN;
				end
				URS_BUS_TURN_IN: begin
					bus_q <= URS_BUS_PHY;
				end
				URS_BUS_PHY: begin
					if (!rxActive && !trigger)
						bus_q <= URS_BUS_TURN_OUT;
				end
				URS_BUS_TURN_OUT: begin
					bus_q <= URS_BUS_LINK;
				end
				default: begin
					bus_q <= URS_BUS_LINK;
				end
			endcase
		end
	end

	// direction high spans turn-in through own cycles
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir <= 1'b0;
		end else begin
			dir <= (bus_q == URS_BUS_LINK && wantBus)
				|| bus_q == URS_BUS_TURN_IN
				|| keepBus;
		end
	end

	// bus drive starts one cycle after direction rises
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dataOe <= 1'b0;
		end else begin
			dataOe <= (bus_q == URS_BUS_TURN_IN) || keepBus;
		end
	end

	// received bytes go out with nxt high, status bytes otherwise
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nxt     <= 1'b0;
			dataOut <= `URS_IDLE_BYTE;
		end else if (bus_q != URS_BUS_LINK && rxActive && rxDataValid) begin
			nxt     <= 1'b1;
			dataOut <= rxData;
		end else begin
			nxt     <= 1'b0;
			dataOut <= statusByte;
		end
	end

	// link data delayed one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			linkData <= `URS_IDLE_BYTE;
		end else begin
			linkData <= dataIn;
		end
	end

	// link data ignored while the bus turns around
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			linkDataValid <= 1'b0;
		end else begin
			linkDataValid <= (bus_q == URS_BUS_LINK) && !dir;
		end
	end
endmodule : urs_rx_status_reporter

// ===== pkg/urs_regs.svh
// timing and field constants for the receive-status reporter
`ifndef URS_REGS_SVH
`define URS_REGS_SVH
`define URS_LS_LSB       0
`define URS_LS_MSB       1
`define URS_VBUS_LSB     2
`define URS_VBUS_MSB     3
`define URS_RXEV_LSB     4
`define URS_RXEV_MSB     5
`define URS_ID_BIT       6
`define URS_ALT_BIT      7
`define URS_IDLE_BYTE    8'h00
`define URS_TURN_CYCLES  1
`endif

// ===== pkg/urs_pkg.sv
// types for the receive-status reporter
package urs_pkg;
	typedef enum logic [1:0] {
		URS_BUS_LINK,
		URS_BUS_TURN_IN,
		URS_BUS_PHY,
		URS_BUS_TURN_OUT
	} urs_bus_e;
	typedef logic [7:0] urs_byte_t;
endpackage : urs_pkg

// ===== verilog/urs_status_byte.sv
`timescale 1ns/1ps
// assembles the receive-status byte from current line and comparator state
`include "urs_regs.svh"
module urs_status_byte
	import urs_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// state inputs
	input  wire logic [1:0] lineState,
	input  wire logic [1:0] vbusState,
	input  wire logic       rxActive,
	input  wire logic       rxError,
	input  wire logic       idState,
	// assembled byte
	output urs_byte_t       statusByte
);
	logic [1:0] rxEvent;

	always_comb begin
		if (rxError)
			rxEvent = 2'h3;
		else if (rxActive)
			rxEvent = 2'h1;
		else
			rxEvent = 2'h0;
	end

	// registered so the byte matches the cycle it is driven
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			statusByte <= 8'h00;
		end else begin
			statusByte[`URS_LS_MSB:`URS_LS_LSB]     <= lineState;
			statusByte[`URS_VBUS_MSB:`URS_VBUS_LSB] <= vbusState;
			statusByte[`URS_RXEV_MSB:`URS_RXEV_LSB] <= rxEvent;
			statusByte[`URS_ID_BIT]                 <= idState;
			statusByte[`URS_ALT_BIT]                <= 1'b0;
		end
	end
endmodule : urs_status_byte

// ===== test/urs_rx_status_monitor.sv
// port assertions for the receive-status reporter
`timescale 1ns/1ps
module urs_rx_status_monitor (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// watched ports
	input wire logic       syncMode,
	input wire logic       txActive,
	input wire logic       stp,
	input wire logic [1:0] lineState,
	input wire logic [1:0] vbusState,
	input wire logic       idState,
	input wire logic       dir,
	input wire logic       nxt,
	input wire logic [7:0] dataOut,
	input wire logic       dataOe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_oe_needs_dir: assert property (dataOe |-> dir)
		else $error("bus driven without dir");
	a_turn_in: assert property ($rose(dir) |-> !dataOe)
		else $error("no turnaround on dir rise");
	a_turn_out: assert property ($fell(dir) |-> !dataOe)
		else $error("no turnaround on dir fall");
	a_sync_only: assert property (!syncMode && !dir |=> !dir)
		else $error("bus taken outside sync mode");
	a_line_report: assert property ($changed(lineState) && syncMode
		&& !txActive && !dir |=> dir) else $error("line change unreported");
	a_comp_report: assert property ($changed({vbusState, idState})
		&& syncMode && !txActive && !dir |=> dir)
		else $error("comparator change unreported");
	a_tx_hold: assert property (txActive && !stp && !dir |=> !dir)
		else $error("status sent during transmit");
	a_line_bits: assert property (dataOe && !nxt && $stable(lineState)
		|-> dataOut[1:0] == lineState) else $error("line bits wrong");
	a_byte_fields: assert property (dataOe && !nxt
		&& $stable({vbusState, idState}) |-> dataOut[3:2] == vbusState
		&& dataOut[6] == idState && !dataOut[7]) else $error("fields wrong");
	c_report: cover property ($rose(dir));
	c_byte: cover property (dataOe && !nxt);
	c_tx_stop: cover property (txActive && stp);
endmodule : urs_rx_status_monitor
bind urs_rx_status_reporter urs_rx_status_monitor u_mon (.sys_clk, .rst_n,
	.syncMode, .txActive, .stp, .lineState, .vbusState, .idState, .dir,
	.nxt, .dataOut, .dataOe);

// ===== test/urs_link_model.sv
// link-side model driving stop and the data bus
`timescale 1ns/1ps
module urs_link_model (
	// clock and ownership
	input wire logic  sys_clk,
	input wire logic  dir,
	input wire logic  stopReq,
	// link pins
	output logic       stp = 1'b0,
	output logic [7:0] dataIn = 8'h00
);
	always @(posedge sys_clk) stp <= stopReq;
	// idle while owning the bus, a toggling pattern once released
	always @(posedge sys_clk) dataIn <= dir ? ~dataIn : 8'h00;
endmodule : urs_link_model

// ===== test/urs_rx_status_reporter_test.sv
// self-checking bench for the receive-status reporter
`timescale 1ns/1ps
module urs_rx_status_reporter_test import urs_pkg::*;;
	logic       sys_clk = 0, rst_n = 0, syncMode = 0, exitLowPower = 0;
	logic       txActive = 0, idState = 0, stopReq = 0, stp, dir, nxt, dataOe;
	logic [1:0] lineState = 0, vbusState = 0;
	logic [7:0] rxData = 0, dataIn, dataOut;
	logic       rxActive = 0, rxError = 0, rxDataValid = 0, linkDataValid;
	logic [7:0] rxPrev = 0, linkData;
	int         fails = 0, n_compared = 0;
	urs_byte_t  q[$], e;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) rxData <= 8'($urandom);
	always @(posedge sys_clk) rxPrev <= rxData;
	urs_rx_status_reporter DUT (.sys_clk, .rst_n, .syncMode, .exitLowPower,
		.txActive, .lineState, .vbusState, .idState, .rxActive,
		.rxError, .rxDataValid, .rxData, .stp, .dataIn, .dir,
		.nxt, .dataOut, .dataOe, .linkData, .linkDataValid);
	urs_link_model u_link (.sys_clk, .dir, .stopReq, .stp, .dataIn);
	always @(posedge sys_clk) if (rst_n && dataOe === 1'b1) begin
		n_compared++;
		if (nxt === 1'b1) begin
			if (dataOut !== rxPrev) begin
				fails++;
				$display("[ERR] %0t data %h expected %h", $time, dataOut,
					rxPrev);
			end
		end else begin
			e = q.size() ? q.pop_front() : 8'hxx;
			if (dataOut !== e) begin
				fails++;
				$display("[ERR] %0t byte %h expected %h", $time, dataOut, e);
			end
		end
	end
	always @(posedge sys_clk) if (rst_n && linkDataValid === 1'b1) begin
		n_compared++;
		if (linkData !== 8'h00) begin
			fails++;
			$display("[ERR] %0t link data %h outside turnaround", $time,
				linkData);
		end
	end
	task conclude;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task settle;
		int i;
		i = 0;
		while (dir !== 1'b1 && i < 20) begin @(posedge sys_clk); i++; end
		i = 0;
		while (dir !== 1'b0 && i < 20) begin @(posedge sys_clk); i++; end
		repeat (3) @(posedge sys_clk);
		$display("test done at %0t", $time);
	endtask : settle
	task trig(input logic [1:0] l, input logic [1:0] v, input logic d);
		@(posedge sys_clk);
		lineState <= l;
		vbusState <= v;
		idState <= d;
		q.push_back({1'b0, d, 2'b00, v, l});
		settle;
	endtask : trig
	task rx_burst(input logic err);
		logic v;
		@(posedge sys_clk);
		rxActive <= 1;
		rxError <= err;
		@(posedge sys_clk);
		for (int k = 0; k < 8; k++) begin
			v = 1'($urandom);
			rxDataValid <= v;
			if (!v)
				q.push_back({1'b0, idState, (err ? 2'b11 : 2'b01),
					vbusState, lineState});
			@(posedge sys_clk);
		end
		rxActive <= 0;
		rxError <= 0;
		rxDataValid <= 0;
		settle;
	endtask : rx_burst
	task stop_pulse(input logic low);
		q.push_back({1'b0, idState, 2'b00, vbusState, lineState});
		stopReq <= 1;
		exitLowPower <= low;
		repeat (2) @(posedge sys_clk);
		stopReq <= 0;
		exitLowPower <= 0;
		txActive <= 0;
		settle;
	endtask : stop_pulse
	initial begin
		void'($urandom(53051));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1;
		repeat (4) @(posedge sys_clk);
		syncMode <= 1;
		q.push_back(8'h00);
		settle;
		for (int k = 0; k < 4; k++)
			trig(lineState ^ 2'($urandom_range(1, 3)), vbusState,
				idState);
		trig(lineState, vbusState + 2'h1, idState);
		trig(lineState, vbusState, ~idState);
		trig(~lineState, ~vbusState, ~idState);
		rx_burst(1'b0);
		rx_burst(1'b1);
		@(posedge sys_clk);
		txActive <= 1;
		vbusState <= vbusState + 2'h1;
		repeat (10) @(posedge sys_clk);
		n_compared++;
		if (dir !== 1'b0) begin
			fails++;
			$display("[ERR] %0t status during transmit", $time);
		end
		stop_pulse(1'b0);
		stop_pulse(1'b1);
		n_compared++;
		if (q.size() != 0) begin
			fails++;
			$display("[ERR] %0t missing status bytes", $time);
		end
		conclude;
	end
	initial begin
		#20000;
		fails++;
		conclude;
	end
endmodule : urs_rx_status_reporter_test
